// file: src/lvd_pkg.sv
package lvd_pkg;
    localparam logic [15:0] LVC_ADDR      = 16'hFFBE;
    localparam logic [15:0] LVS_ADDR      = 16'hFFBF;
    localparam logic [15:0] P12D_ADDR     = 16'hFF2C;
    localparam logic [7:0]  LVC_RESET     = 8'h00;
    localparam logic [7:0]  LVS_RESET     = 8'h00;
    localparam logic [7:0]  P12D_RESET    = 8'hFF;
    localparam int          EN_BIT        = 7;
    localparam int          SRC_BIT       = 2;
    localparam int          MODE_BIT      = 1;
    localparam int          FLAG_BIT      = 0;
    localparam int          LEVEL_BIT     = 0;
    localparam int          CLK_MHZ       = 100;
    localparam int          FILTER_US     = 200;
    localparam int          FILTER_CYC    = FILTER_US * CLK_MHZ;
    localparam int          STABLE_US     = 10;
    localparam int          STABLE_CYC    = STABLE_US * CLK_MHZ;
endpackage

// file: src/lvd_filter_if.sv
`timescale 1ns/1ns
interface lvd_filter_if;
    logic raw_below;
    logic enable;
    logic below;
    modport filt (input raw_below, input enable, output below);
    modport ctrl (output raw_below, output enable, input below);
endinterface

// file: src/lvd_filter.sv
`timescale 1ns/1ns
module lvd_filter
    import lvd_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic reset_i,
    lvd_filter_if.filt f
);
    logic [14:0] cnt_r;
    logic [14:0] cnt_nxt;
    logic        below_r;
    logic        below_nxt;

    assign f.below = below_r;

    // [RULE6] glitch filter: low must persist 200 us before the flag sets
    always_comb begin
        cnt_nxt   = cnt_r;
        below_nxt = below_r;
        if (!f.enable || !f.raw_below) begin
            cnt_nxt   = '0;
            below_nxt = 1'b0;
        end else if (cnt_r < 15'(FILTER_CYC - 1)) begin
            cnt_nxt = cnt_r + 15'h1;
        end else begin
            below_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cnt_r   <= '0;
            below_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            below_r <= below_nxt;
        end
    end

    a_filter_short_pulse: assert property (@(posedge mclk_i) // [RULE6]
        disable iff (reset_i) $rose(below_r) |-> cnt_r == 15'(FILTER_CYC - 1))
        else $error("flag set before filter time");
endmodule // lvd_filter

// file: src/low_voltage_detector_control.sv
`timescale 1ns/1ns
// Functional notes
// [RULE1] non-detector reset clears control to 00H; detector reset keeps it
// [RULE2] control: enable b7, source b2, mode b1, flag b0, b6..b3 zero
// [RULE3] flag reads 1 only while enabled and selected voltage is below
// [RULE4] enable 0 disables detection; enable 1 starts the comparator
// [RULE5] software waits 10 us after enabling before trusting the flag
// [RULE6] flag sets only after the low level lasts 200 us
// [RULE7] source 0 compares supply, source 1 compares external pin
// [RULE8] reset mode holds internal reset while below, releases when above
// [RULE9] interrupt mode raises interrupt on falling and rising crossings
// [RULE10] clearing enable while below in interrupt mode raises interrupt
// [RULE11] software stops detection by writing 00H or clearing enable
// [RULE12] external source uses fixed threshold, ignores level select
// [RULE13] level select bit 0 picks supply threshold; bits 7..1 zero
// [RULE14] level select survives detector reset, else cleared to 00H
// [RULE15] software leaves level select alone while detection is enabled
// [RULE16] software sets port 12 pin 0 to input to use external pin
// [RULE17] every reset sets port 12 direction to FFH
// [RULE18] direction 0 drives pins 0..2 out, 1 turns buffer off
// [RULE19] detector reset sets the detector reset cause flag
// [RULE20] any reset sets the detector interrupt mask flag
// [RULE21] comparator outputs pass a two-stage synchroniser first
// [RULE22] each synchronised crossing gives one interrupt pulse; code pulses only on filtered crossings, none for lows under 200 us
module low_voltage_detector_control
    import lvd_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic       det_reset_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    output logic      [7:0] rdata_o,
    input  wire logic       supply_below_i,
    input  wire logic       ext_below_i,
    output logic            comparator_on_o,
    output logic            source_select_o,
    output logic            level_choice_o,
    output logic            det_reset_o,
    output logic            detector_interrupt_o,
    output logic            detector_reset_cause_o,
    output logic            detector_irq_mask_set_o,
    output logic      [2:0] port12_out_enable_o
);
    logic       en_r, en_nxt;
    logic       src_r, src_nxt;
    logic       mode_r, mode_nxt;
    logic       lvl_r, lvl_nxt;
    logic [7:0] dir_r, dir_nxt;
    logic [1:0] sup_sync_r, ext_sync_r;
    logic       sel_prev_r, sel_prev_nxt;
    logic       irq_r, irq_nxt;
    logic       rst_r, rst_nxt;
    logic       cause_r, cause_nxt;
    logic       mask_r, mask_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       lvl_out_r, lvl_out_nxt;
    logic [2:0] oe_r, oe_nxt;
    logic       sel_below;
    logic       any_reset;

    lvd_filter_if fif ();

    assign any_reset = reset_i | det_reset_i;

    // [RULE7] source mux after synchronising both comparators
    assign sel_below      = src_r ? ext_sync_r[1] : sup_sync_r[1];
    assign fif.raw_below  = sel_below;
    // [RULE4] detection runs only while enabled
    assign fif.enable     = en_r;

    lvd_filter u_filter (
        .mclk_i  (mclk_i),
        .reset_i (any_reset),
        .f       (fif.filt)
    );

    // [RULE21] two-flop synchronisers, first stage read only by second
    always_ff @(posedge mclk_i) begin
        sup_sync_r <= {sup_sync_r[0], supply_below_i};
        ext_sync_r <= {ext_sync_r[0], ext_below_i};
    end

    always_comb begin
        en_nxt       = en_r;
        src_nxt      = src_r;
        mode_nxt     = mode_r;
        lvl_nxt      = lvl_r;
        dir_nxt      = dir_r;
        sel_prev_nxt = fif.below;
        irq_nxt      = 1'b0;
        rst_nxt      = 1'b0;
        cause_nxt    = 1'b0;
        mask_nxt     = 1'b0;
        if (wr_i && addr_i == LVC_ADDR) begin
            en_nxt   = wdata_i[EN_BIT];
            src_nxt  = wdata_i[SRC_BIT];
            mode_nxt = wdata_i[MODE_BIT];
        end
        // [RULE13] only bit 0 is stored
        if (wr_i && addr_i == LVS_ADDR) lvl_nxt = wdata_i[LEVEL_BIT];
        if (wr_i && addr_i == P12D_ADDR) dir_nxt = wdata_i;
        // [RULE12] threshold choice is moot on external source
        lvl_out_nxt = lvl_nxt & ~src_nxt;
        // [RULE18] buffer on when direction bit is 0
        oe_nxt = ~dir_nxt[2:0];
        // [RULE8] reset held while filtered level is below
        rst_nxt = en_r && mode_r && fif.below;
        // [RULE9] [RULE22] one pulse per filtered crossing, irq mode
        if (en_r && !mode_r && fif.below != sel_prev_r) irq_nxt = 1'b1;
        // [RULE10] disabling while below still signals
        if (!mode_r && en_r && fif.below && !en_nxt) irq_nxt = 1'b1;
        // [RULE19] mark detector as reset cause
        cause_nxt = det_reset_i;
        // [RULE20] mask on every reset
        mask_nxt = any_reset;
        // [RULE2] [RULE3] readback, unused bits zero
        rdata_nxt = 8'h00;
        if (addr_i == LVC_ADDR) begin
            rdata_nxt[EN_BIT]   = en_r;
            rdata_nxt[SRC_BIT]  = src_r;
            rdata_nxt[MODE_BIT] = mode_r;
            rdata_nxt[FLAG_BIT] = en_r & fif.below;
        end else if (addr_i == LVS_ADDR) begin
            rdata_nxt[LEVEL_BIT] = lvl_r;
        end else if (addr_i == P12D_ADDR) begin
            rdata_nxt = dir_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            // [RULE1] [RULE14] full clear on ordinary reset
            en_r   <= LVC_RESET[EN_BIT];
            src_r  <= LVC_RESET[SRC_BIT];
            mode_r <= LVC_RESET[MODE_BIT];
            lvl_r  <= LVS_RESET[LEVEL_BIT];
            lvl_out_r <= LVS_RESET[LEVEL_BIT] & ~LVC_RESET[SRC_BIT];
        end else begin
            en_r   <= det_reset_i ? en_r : en_nxt;
            src_r  <= det_reset_i ? src_r : src_nxt;
            mode_r <= det_reset_i ? mode_r : mode_nxt;
            lvl_r  <= det_reset_i ? lvl_r : lvl_nxt;
            lvl_out_r <= det_reset_i ? lvl_out_r : lvl_out_nxt;
        end
        // [RULE17] every reset restores all inputs
        if (any_reset) begin
            dir_r <= P12D_RESET;
            oe_r  <= ~P12D_RESET[2:0];
        end else begin
            dir_r <= dir_nxt;
            oe_r  <= oe_nxt;
        end
        if (any_reset) begin
            sel_prev_r <= 1'b0;
            irq_r      <= 1'b0;
            rst_r      <= 1'b0;
            rdata_r    <= 8'h00;
        end else begin
            sel_prev_r <= sel_prev_nxt;
            irq_r      <= irq_nxt;
            rst_r      <= rst_nxt;
            rdata_r    <= rdata_nxt;
        end
        if (reset_i) begin
            cause_r <= 1'b0;
            mask_r  <= 1'b1;
        end else begin
            cause_r <= cause_nxt;
            mask_r  <= mask_nxt;
        end
    end

    assign rdata_o                 = rdata_r;
    assign comparator_on_o         = en_r;
    assign source_select_o         = src_r;
    // [RULE12] registered so the threshold pick never glitches
    assign level_choice_o          = lvl_out_r;
    assign det_reset_o             = rst_r;
    assign detector_interrupt_o    = irq_r;
    assign detector_reset_cause_o  = cause_r;
    assign detector_irq_mask_set_o = mask_r;
    // [RULE18] registered copy of inverted direction bits
    assign port12_out_enable_o     = oe_r;

    a_reset_follows_level: assert property (@(posedge mclk_i) // [RULE8]
        disable iff (any_reset)
        (en_r && mode_r && fif.below) |=> rst_r)
        else $error("reset mode did not assert");
    a_irq_on_crossing: assert property (@(posedge mclk_i) // [RULE9]
        disable iff (any_reset)
        (en_r && !mode_r && $changed(fif.below)) |=> irq_r)
        else $error("crossing without interrupt");
    a_flag_zero_off: assert property (@(posedge mclk_i) // [RULE3]
        disable iff (any_reset)
        (!en_r && addr_i == LVC_ADDR) |=> !rdata_r[FLAG_BIT])
        else $error("flag set while disabled");
    a_dir_after_reset: assert property (@(posedge mclk_i) // [RULE17]
        any_reset |=> dir_r == P12D_RESET)
        else $error("direction not FFH after reset");
    a_mask_after_reset: assert property (@(posedge mclk_i) // [RULE20]
        any_reset |=> mask_r)
        else $error("mask not set by reset");
    a_cause_on_detreset: assert property (@(posedge mclk_i) // [RULE19]
        disable iff (reset_i) det_reset_i |=> cause_r)
        else $error("reset cause not set");
    a_keep_on_detreset: assert property (@(posedge mclk_i) // [RULE1]
        disable iff (reset_i) det_reset_i |=> $stable(en_r) && $stable(lvl_r))
        else $error("detector reset changed settings");
    a_level_ignored_ext: assert property (@(posedge mclk_i) // [RULE12]
        disable iff (any_reset) src_r |-> !level_choice_o)
        else $error("level used on external source");
    a_irq_on_disable: assert property (@(posedge mclk_i) // [RULE10]
        disable iff (any_reset)
        (en_r && !mode_r && fif.below && wr_i && addr_i == LVC_ADDR
            && !wdata_i[EN_BIT]) |=> irq_r)
        else $error("disable while below gave no interrupt");
    a_oe_follows_dir: assert property (@(posedge mclk_i) // [RULE18]
        disable iff (any_reset) port12_out_enable_o == ~dir_r[2:0])
        else $error("pin buffer does not follow direction");
    a_flag_readback: assert property (@(posedge mclk_i) // [RULE3]
        disable iff (any_reset)
        (en_r && addr_i == LVC_ADDR)
            |=> rdata_r[FLAG_BIT] == $past(fif.below))
        else $error("flag does not show filtered level");
    a_level_clear_reset: assert property (@(posedge mclk_i) // [RULE14]
        reset_i |=> !lvl_r && !level_choice_o)
        else $error("level select survived ordinary reset");
    a_cause_only_det: assert property (@(posedge mclk_i) // [RULE19]
        disable iff (reset_i) !det_reset_i |=> !cause_r)
        else $error("reset cause set without detector reset");
endmodule // low_voltage_detector_control

// file: testbench/lvd_comparator_model.sv
`timescale 1ns/1ns
module lvd_comparator_model (
    input  wire logic mclk_i,
    input  wire logic comparator_on_i,
    input  wire logic pin_drive_i,
    input  wire logic supply_low_i,
    input  wire logic ext_low_i,
    output logic      supply_below_o,
    output logic      ext_below_o
);
    logic junk_r = 1'b0;
    // unpowered or shorted input gives no steady answer
    always @(posedge mclk_i) junk_r <= #3 ~junk_r;
    assign supply_below_o = comparator_on_i ? supply_low_i : junk_r;
    // pin readable only with its buffer off
    assign ext_below_o = (comparator_on_i && !pin_drive_i) ? ext_low_i
                                                            : junk_r;
endmodule // lvd_comparator_model

// file: testbench/test_low_voltage_detector_control.sv
`timescale 1ns/1ns
module test_low_voltage_detector_control;
    import lvd_pkg::*;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        det_reset_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        s_low = 1'b0;
    logic        e_low = 1'b0;
    logic [7:0]  rdata_o;
    logic        supply_below_i, ext_below_i, comparator_on_o;
    logic        source_select_o, level_choice_o, det_reset_o;
    logic        detector_interrupt_o, detector_reset_cause_o;
    logic        detector_irq_mask_set_o;
    logic [2:0]  port12_out_enable_o;
    int          error_cnt = 0;
    int          check_count = 0;
    int          n;
    low_voltage_detector_control u_dut (.mclk_i, .reset_i, .det_reset_i,
        .addr_i, .wdata_i, .wr_i, .rdata_o, .supply_below_i, .ext_below_i,
        .comparator_on_o, .source_select_o, .level_choice_o, .det_reset_o,
        .detector_interrupt_o, .detector_reset_cause_o,
        .detector_irq_mask_set_o, .port12_out_enable_o);
    lvd_comparator_model u_model (.mclk_i, .comparator_on_i(comparator_on_o),
        .pin_drive_i(port12_out_enable_o[0]), .supply_low_i(s_low),
        .ext_low_i(e_low), .supply_below_o(supply_below_i),
        .ext_below_o(ext_below_i));
    initial forever #5 mclk_i = ~mclk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int lo, input int hi);
        chk(8'((got >= lo) && (got <= hi)), 8'h01);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge mclk_i);
        wr_i = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        @(negedge mclk_i);
        addr_i = a;
        @(negedge mclk_i);
        chk(rdata_o & m, e);
    endtask
    function automatic logic hit(input int s);
        case (s)
            0: return det_reset_o === 1'b1;
            1: return det_reset_o === 1'b0;
            2: return detector_interrupt_o === 1'b1;
            default: return detector_reset_cause_o === 1'b1;
        endcase
    endfunction
    // bounded wait; n returns cycles spent
    task automatic wt(input int s, input int lim);
        n = 0;
        while (!hit(s) && n < lim) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("[ERR] %0t wait %0d ran out", $time, s);
            close_out();
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset_vals();
        chk({7'h00, detector_irq_mask_set_o}, 8'h01);
        @(negedge mclk_i);
        reset_i = 1'b0;
        rd(LVC_ADDR, 8'hFF, 8'h00);
        rd(LVS_ADDR, 8'hFF, 8'h00);
        rd(P12D_ADDR, 8'hFF, 8'hFF);
        chk({5'h00, port12_out_enable_o}, 8'h00);
    endtask
    task automatic t_fields();
        wr(LVS_ADDR, 8'hFF);
        rd(LVS_ADDR, 8'hFF, 8'h01);
        chk({7'h00, level_choice_o}, 8'h01);
        wr(P12D_ADDR, 8'hFA);
        chk({5'h00, port12_out_enable_o}, 8'h05);
        wr(P12D_ADDR, 8'hFF);
        wr(LVC_ADDR, 8'hFF);
        rd(LVC_ADDR, 8'hFF, 8'h86);
        chk({6'h00, comparator_on_o, source_select_o}, 8'h03);
        chk({7'h00, level_choice_o}, 8'h00);
        // ordinary reset in mid-run must clear both registers
        @(negedge mclk_i);
        reset_i = 1'b1;
        @(negedge mclk_i);
        chk({7'h00, detector_irq_mask_set_o}, 8'h01);
        reset_i = 1'b0;
        rd(LVC_ADDR, 8'hFF, 8'h00);
        rd(LVS_ADDR, 8'hFF, 8'h00);
        wr(LVS_ADDR, 8'h01);
    endtask
    task automatic t_reset_mode();
        wr(LVC_ADDR, 8'h80);
        repeat (STABLE_CYC) @(negedge mclk_i);
        wr(LVC_ADDR, 8'h82);
        s_low = 1'b1;
        wt(0, 21000);
        chk_n(n, FILTER_CYC - 2, FILTER_CYC + 100);
        rd(LVC_ADDR, 8'hFF, 8'h83);
        s_low = 1'b0;
        wt(1, 10);
        rd(LVC_ADDR, 8'hFF, 8'h82);
        wr(P12D_ADDR, 8'hF8);
        @(negedge mclk_i);
        det_reset_i = 1'b1;
        @(negedge mclk_i);
        det_reset_i = 1'b0;
        wt(3, 5);
        chk({7'h00, detector_irq_mask_set_o}, 8'h01);
        rd(LVC_ADDR, 8'hFF, 8'h82);
        rd(LVS_ADDR, 8'hFF, 8'h01);
        rd(P12D_ADDR, 8'hFF, 8'hFF);
        wr(LVC_ADDR, 8'h00);
    endtask
    task automatic t_irq_mode();
        wr(P12D_ADDR, 8'hFF);
        wr(LVC_ADDR, 8'h84);
        repeat (STABLE_CYC) @(negedge mclk_i);
        e_low = 1'b1;
        repeat (1000) @(negedge mclk_i);
        e_low = 1'b0;
        repeat (10) @(negedge mclk_i);
        e_low = 1'b1;
        wt(2, 21000);
        chk_n(n, FILTER_CYC - 2, FILTER_CYC + 100);
        rd(LVC_ADDR, 8'hFF, 8'h85);
        e_low = 1'b0;
        @(negedge mclk_i);
        wt(2, 21000);
        @(negedge mclk_i);
        chk({7'h00, detector_interrupt_o}, 8'h00);
        rd(LVC_ADDR, 8'hFF, 8'h84);
        e_low = 1'b1;
        @(negedge mclk_i);
        wt(2, 21000);
        wr(LVC_ADDR, 8'h00);
        wt(2, 10);
        chk({7'h00, det_reset_o}, 8'h00);
    endtask
    initial begin
        repeat (20) @(negedge mclk_i);
        t_reset_vals();
        t_fields();
        t_reset_mode();
        t_irq_mode();
        close_out();
    end
endmodule // test_low_voltage_detector_control
